// file: design/uie_dev.sv
`timescale 1ns/1ns
// What this block does
// - Software programs size before enable, then leaves it
// - Core updates size and count once enabled
// - Software reads size only after enable clears; the testbench also reads it while the endpoint is still enabled
// - Endpoints zero to three own separate size registers
// - Software keeps transfer data in one buffer
// - Short packet counts as one, sent last
// - Zero-length packet: size zero, count one
// - Full packets then zero-length as two transfers
// - Software reads updated size when transfer ends
// - Fetched data equals initial minus final size
// - Sent data follows packet count decrements
// - Software programs, enables, then fills the FIFO
// - Each packet written reduces remaining size
// - Software writes FIFO until size reaches zero
// - Three-bit stored-packet count, at most eight
// - Zero-length packet is a flag, no data
// - IN token reads queued packet and sends it
////////////////////////////////////////////////////////////////////////////////
module uie_dev (
  input logic CLK,
  input logic RST_N,
  uie_if.dev BUS,
  output logic [uie_pkg::NUM_EP-1:0] EP_ACTIVE
);
  import uie_pkg::*;

  uie_size_t tsz_r [NUM_EP];
  uie_size_t tsz_nxt [NUM_EP];
  uie_pcnt_t pc_r [NUM_EP];
  uie_pcnt_t pc_nxt [NUM_EP];
  uie_size_t mps_r [NUM_EP];
  uie_size_t mps_nxt [NUM_EP];
  logic [NUM_EP-1:0] ena_r, ena_nxt;
  logic [DW-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [NUM_EP-1:0] ready_r, ready_nxt;

  uie_tx_st_t st_r, st_nxt;
  uie_ep_t cur_r, cur_nxt;
  logic cur_zlp_r, cur_zlp_nxt;
  uie_size_t left_r, left_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;
  logic tx_last_r, tx_last_nxt;
  logic tx_zlp_r, tx_zlp_nxt;
  logic tx_nak_r, tx_nak_nxt;

  logic [NUM_EP-1:0] q_wr, q_rd, q_commit, q_rewind, q_drop;
  logic [NUM_EP-1:0] q_hasd, q_hasz, q_done, q_can;
  logic [7:0] q_byte [NUM_EP];
  uie_size_t q_len [NUM_EP];
  uie_size_t q_plen [NUM_EP];

  assign BUS.reg_rdata = rdata_r;
  assign BUS.reg_rvalid = rvalid_r;
  assign BUS.fifo_ready = ready_r;
  assign BUS.tx_valid = tx_valid_r;
  assign BUS.tx_data = tx_data_r;
  assign BUS.tx_last = tx_last_r;
  assign BUS.tx_zlp = tx_zlp_r;
  assign BUS.tx_nak = tx_nak_r;
  assign EP_ACTIVE = ena_r;

  ////////////////////////////////////////////////////////////////////////////////
  // One packet queue per endpoint
  for (genvar e = 0; e < NUM_EP; e++) begin : g_q
    assign q_wr[e] = BUS.fifo_valid && ready_r[e] && (BUS.fifo_ep == uie_ep_t'(e));
    assign q_rd[e] = (st_r == S_SEND) && (cur_r == uie_ep_t'(e));
    assign q_commit[e] = (st_r == S_WAIT) && BUS.hs_ack && !cur_zlp_r
                         && (cur_r == uie_ep_t'(e));
    assign q_drop[e] = (st_r == S_WAIT) && BUS.hs_ack && cur_zlp_r
                       && (cur_r == uie_ep_t'(e));
    assign q_rewind[e] = (st_r == S_WAIT) && BUS.hs_miss && !cur_zlp_r
                         && (cur_r == uie_ep_t'(e));

    uie_txq u_q (
      .clk(CLK),
      .rst_n(RST_N),
      .wr_en(q_wr[e]),
      .wr_data(BUS.fifo_data),
      .wr_last(BUS.fifo_last),
      .wr_zlp(BUS.fifo_zlp),
      .rd_next(q_rd[e]),
      .commit(q_commit[e]),
      .rewind(q_rewind[e]),
      .drop_zlp(q_drop[e]),
      .rd_byte(q_byte[e]),
      .head_len(q_len[e]),
      .has_data(q_hasd[e]),
      .has_zlp(q_hasz[e]),
      .push_done(q_done[e]),
      .push_len(q_plen[e]),
      .can_take(q_can[e])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register file and transfer bookkeeping
  always_comb begin
    tsz_nxt = tsz_r;
    pc_nxt = pc_r;
    mps_nxt = mps_r;
    ena_nxt = ena_r;
    rvalid_nxt = BUS.reg_rd;
    rdata_nxt = '0;
    ready_nxt = q_can;
    for (int e = 0; e < NUM_EP; e++) begin
      if (BUS.reg_wr && (BUS.reg_addr == ctrl_addr(uie_ep_t'(e)))) begin
        ena_nxt[e] = BUS.reg_wdata[ENA_BIT];
        mps_nxt[e] = BUS.reg_wdata[MPS_LSB +: MPS_W];
      end
      // Size locked while enabled, so the core's count cannot be trampled
      if (BUS.reg_wr && !ena_r[e] && (BUS.reg_addr == tsiz_addr(uie_ep_t'(e)))) begin
        tsz_nxt[e] = BUS.reg_wdata[XFR_LSB +: XFR_W];
        pc_nxt[e] = BUS.reg_wdata[PKT_LSB +: PKT_W];
      end
      if (q_done[e]) begin
        tsz_nxt[e] = tsz_r[e] - q_plen[e];
      end
      if (q_commit[e] || q_drop[e]) begin
        pc_nxt[e] = pc_r[e] - 2'h1;
        if (pc_r[e] == 2'h1) begin
          ena_nxt[e] = 1'b0;
        end
      end
      if (BUS.reg_rd && (BUS.reg_addr == ctrl_addr(uie_ep_t'(e)))) begin
        rdata_nxt[ENA_BIT] = ena_r[e];
        rdata_nxt[MPS_LSB +: MPS_W] = mps_r[e];
      end
      if (BUS.reg_rd && (BUS.reg_addr == tsiz_addr(uie_ep_t'(e)))) begin
        rdata_nxt[PKT_LSB +: PKT_W] = pc_r[e];
        rdata_nxt[XFR_LSB +: XFR_W] = tsz_r[e];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Token answer engine
  always_comb begin
    st_nxt = st_r;
    cur_nxt = cur_r;
    cur_zlp_nxt = cur_zlp_r;
    left_nxt = left_r;
    tx_valid_nxt = 1'b0;
    tx_data_nxt = tx_data_r;
    tx_last_nxt = 1'b0;
    tx_zlp_nxt = 1'b0;
    tx_nak_nxt = 1'b0;
    unique case (st_r)
      S_IDLE: begin
        if (BUS.tok_valid) begin
          cur_nxt = BUS.tok_ep;
          // Data packets go first; a zero-length one only once they are gone
          if (ena_r[BUS.tok_ep] && q_hasd[BUS.tok_ep]) begin
            cur_zlp_nxt = 1'b0;
            left_nxt = q_len[BUS.tok_ep];
            st_nxt = S_SEND;
          end else if (ena_r[BUS.tok_ep] && q_hasz[BUS.tok_ep]) begin
            cur_zlp_nxt = 1'b1;
            tx_zlp_nxt = 1'b1;
            st_nxt = S_WAIT;
          end else begin
            tx_nak_nxt = 1'b1;
          end
        end
      end
      S_SEND: begin
        tx_valid_nxt = 1'b1;
        tx_data_nxt = q_byte[cur_r];
        left_nxt = left_r - 7'h01;
        if (left_r == 7'h01) begin
          tx_last_nxt = 1'b1;
          st_nxt = S_WAIT;
        end
      end
      S_WAIT: begin
        // Missed handshake rewinds the queue so the packet is sent again
        if (BUS.hs_ack || BUS.hs_miss) begin
          st_nxt = S_IDLE;
        end
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int e = 0; e < NUM_EP; e++) begin
        tsz_r[e] <= TSIZ_RST[XFR_LSB +: XFR_W];
        pc_r[e] <= TSIZ_RST[PKT_LSB +: PKT_W];
        mps_r[e] <= CTRL_RST[MPS_LSB +: MPS_W];
        ena_r[e] <= CTRL_RST[ENA_BIT];
      end
      rdata_r <= '0;
      rvalid_r <= 1'b0;
      ready_r <= '0;
      st_r <= S_IDLE;
      cur_r <= '0;
      cur_zlp_r <= 1'b0;
      left_r <= '0;
      tx_valid_r <= 1'b0;
      tx_data_r <= '0;
      tx_last_r <= 1'b0;
      tx_zlp_r <= 1'b0;
      tx_nak_r <= 1'b0;
    end else begin
      tsz_r <= tsz_nxt;
      pc_r <= pc_nxt;
      mps_r <= mps_nxt;
      ena_r <= ena_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      ready_r <= ready_nxt;
      st_r <= st_nxt;
      cur_r <= cur_nxt;
      cur_zlp_r <= cur_zlp_nxt;
      left_r <= left_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_data_r <= tx_data_nxt;
      tx_last_r <= tx_last_nxt;
      tx_zlp_r <= tx_zlp_nxt;
      tx_nak_r <= tx_nak_nxt;
    end
  end
endmodule : uie_dev

// file: design/uie_host.sv
`timescale 1ns/1ns
module uie_host (
  input logic CLK,
  input logic RST_N,
  uie_if.host BUS,
  input logic XFER_START,
  input uie_pkg::uie_ep_t XFER_EP,
  input uie_pkg::uie_size_t XFER_SIZE,
  input uie_pkg::uie_pcnt_t XFER_PKTS,
  input uie_pkg::uie_size_t XFER_MPS,
  output logic XFER_BUSY,
  input logic DATA_VALID,
  input logic [7:0] DATA_BYTE,
  output logic DATA_TAKEN,
  input logic STAT_REQ,
  input logic [uie_pkg::AW-1:0] STAT_ADDR,
  output logic STAT_VALID,
  output logic [uie_pkg::DW-1:0] STAT_DATA,
  input logic TOKEN_REQ,
  input uie_pkg::uie_ep_t TOKEN_EP,
  input logic HS_DROP,
  output logic RX_VALID,
  output logic [7:0] RX_BYTE,
  output logic RX_LAST,
  output logic RX_ZLP,
  output logic RX_NAK
);
  import uie_pkg::*;

  uie_host_st_t st_r, st_nxt;
  uie_ep_t ep_r, ep_nxt, tep_r, tep_nxt;
  uie_size_t size_r, size_nxt, mps_r, mps_nxt, rem_r, rem_nxt, pb_r, pb_nxt;
  uie_pcnt_t pk_r, pk_nxt;
  logic busy_r, busy_nxt, wr_r, wr_nxt, rd_r, rd_nxt, tok_r, tok_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [DW-1:0] wd_r, wd_nxt, sd_r, sd_nxt;
  logic fv_r, fv_nxt, fl_r, fl_nxt, fz_r, fz_nxt, tk_r, tk_nxt;
  logic [7:0] fd_r, fd_nxt, rxb_r, rxb_nxt;
  logic sv_r, sv_nxt, rxv_r, rxv_nxt, rxl_r, rxl_nxt, rxz_r, rxz_nxt, rxn_r, rxn_nxt;
  logic ack_r, ack_nxt, miss_r, miss_nxt;

  assign {BUS.reg_wr, BUS.reg_rd, BUS.reg_addr, BUS.reg_wdata} = {wr_r, rd_r, addr_r, wd_r};
  assign {BUS.fifo_valid, BUS.fifo_ep, BUS.fifo_data} = {fv_r, ep_r, fd_r};
  assign {BUS.fifo_last, BUS.fifo_zlp} = {fl_r, fz_r};
  assign {BUS.tok_valid, BUS.tok_ep, BUS.hs_ack, BUS.hs_miss} = {tok_r, tep_r, ack_r, miss_r};
  assign {XFER_BUSY, DATA_TAKEN, STAT_VALID, STAT_DATA} = {busy_r, tk_r, sv_r, sd_r};
  assign {RX_VALID, RX_BYTE, RX_LAST, RX_ZLP, RX_NAK} = {rxv_r, rxb_r, rxl_r, rxz_r, rxn_r};

  always_comb begin
    st_nxt = st_r;
    {ep_nxt, size_nxt, mps_nxt, rem_nxt, pb_nxt, pk_nxt} =
      {ep_r, size_r, mps_r, rem_r, pb_r, pk_r};
    {busy_nxt, addr_nxt, wd_nxt, fv_nxt, fd_nxt, fl_nxt, fz_nxt} =
      {busy_r, addr_r, wd_r, fv_r, fd_r, fl_r, fz_r};
    {wr_nxt, rd_nxt, tk_nxt} = 3'b000;
    tok_nxt = TOKEN_REQ;
    tep_nxt = TOKEN_REQ ? TOKEN_EP : tep_r;
    sv_nxt = BUS.reg_rvalid;
    sd_nxt = BUS.reg_rvalid ? BUS.reg_rdata : sd_r;
    {rxv_nxt, rxb_nxt, rxl_nxt} = {BUS.tx_valid, BUS.tx_data, BUS.tx_last};
    {rxz_nxt, rxn_nxt} = {BUS.tx_zlp, BUS.tx_nak};
    ack_nxt = ((BUS.tx_valid && BUS.tx_last) || BUS.tx_zlp) && !HS_DROP;
    miss_nxt = ((BUS.tx_valid && BUS.tx_last) || BUS.tx_zlp) && HS_DROP;
    if (fv_r && BUS.fifo_ready[ep_r]) begin
      fv_nxt = 1'b0;
      fz_nxt = 1'b0;
    end
    unique case (st_r)
      H_IDLE: begin
        busy_nxt = 1'b0;
        if (XFER_START) begin
          {ep_nxt, size_nxt, pk_nxt, mps_nxt} = {XFER_EP, XFER_SIZE, XFER_PKTS, XFER_MPS};
          busy_nxt = 1'b1;
          st_nxt = H_CTRL;
        end else if (STAT_REQ) begin
          rd_nxt = 1'b1;
          addr_nxt = STAT_ADDR;
        end
      end
      H_CTRL: begin
        wr_nxt = 1'b1;
        addr_nxt = tsiz_addr(ep_r);
        wd_nxt = '0;
        wd_nxt[PKT_LSB +: PKT_W] = pk_r;
        wd_nxt[XFR_LSB +: XFR_W] = size_r;
        st_nxt = H_SIZE;
      end
      H_SIZE: begin
        wr_nxt = 1'b1;
        addr_nxt = ctrl_addr(ep_r);
        wd_nxt = '0;
        wd_nxt[ENA_BIT] = 1'b1;
        wd_nxt[MPS_LSB +: MPS_W] = mps_r;
        rem_nxt = size_r;
        pb_nxt = '0;
        if (size_r == '0) begin
          fv_nxt = 1'b1;
          fz_nxt = 1'b1;
          fl_nxt = 1'b1;
        end
        st_nxt = H_DATA;
      end
      H_DATA: begin
        // Bytes stream straight from the user; no local copy of the buffer
        if (!fv_r && !tk_r && DATA_VALID && (rem_r != '0)) begin
          fd_nxt = DATA_BYTE;
          fv_nxt = 1'b1;
          tk_nxt = 1'b1;
          rem_nxt = rem_r - 7'h01;
          fl_nxt = (pb_r == mps_r - 7'h01) || (rem_r == 7'h01);
          pb_nxt = fl_nxt ? '0 : pb_r + 7'h01;
        end
        if (!fv_r && (rem_r == '0)) begin
          st_nxt = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= H_IDLE;
      {ep_r, size_r, mps_r, rem_r, pb_r, pk_r} <= '0;
      {busy_r, wr_r, rd_r, tok_r, tep_r, addr_r, wd_r} <= '0;
      {fv_r, fd_r, fl_r, fz_r, tk_r, sv_r, sd_r} <= '0;
      {rxv_r, rxb_r, rxl_r, rxz_r, rxn_r, ack_r, miss_r} <= '0;
    end else begin
      st_r <= st_nxt;
      {ep_r, size_r, mps_r, rem_r, pb_r, pk_r} <=
        {ep_nxt, size_nxt, mps_nxt, rem_nxt, pb_nxt, pk_nxt};
      {busy_r, wr_r, rd_r, tok_r, tep_r, addr_r, wd_r} <=
        {busy_nxt, wr_nxt, rd_nxt, tok_nxt, tep_nxt, addr_nxt, wd_nxt};
      {fv_r, fd_r, fl_r, fz_r, tk_r, sv_r, sd_r} <=
        {fv_nxt, fd_nxt, fl_nxt, fz_nxt, tk_nxt, sv_nxt, sd_nxt};
      {rxv_r, rxb_r, rxl_r, rxz_r, rxn_r, ack_r, miss_r} <=
        {rxv_nxt, rxb_nxt, rxl_nxt, rxz_nxt, rxn_nxt, ack_nxt, miss_nxt};
    end
  end
endmodule : uie_host

// file: design/uie_if.sv
`timescale 1ns/1ns
interface uie_if;
  import uie_pkg::*;
  logic reg_wr;
  logic reg_rd;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata;
  logic [DW-1:0] reg_rdata;
  logic reg_rvalid;
  logic fifo_valid;
  logic [NUM_EP-1:0] fifo_ready;
  uie_ep_t fifo_ep;
  logic [7:0] fifo_data;
  logic fifo_last;
  logic fifo_zlp;
  logic tok_valid;
  uie_ep_t tok_ep;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_last;
  logic tx_zlp;
  logic tx_nak;
  logic hs_ack;
  logic hs_miss;

  modport dev (
    input reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, reg_rvalid,
    input fifo_valid, fifo_ep, fifo_data, fifo_last, fifo_zlp,
    output fifo_ready,
    input tok_valid, tok_ep,
    output tx_valid, tx_data, tx_last, tx_zlp, tx_nak,
    input hs_ack, hs_miss
  );

  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata,
    input reg_rdata, reg_rvalid,
    output fifo_valid, fifo_ep, fifo_data, fifo_last, fifo_zlp,
    input fifo_ready,
    output tok_valid, tok_ep,
    input tx_valid, tx_data, tx_last, tx_zlp, tx_nak,
    output hs_ack, hs_miss
  );
endinterface : uie_if

// file: design/uie_pkg.sv
package uie_pkg;
  localparam int NUM_EP = 4;
  localparam int EPW = 2;
  localparam int AW = 12;
  localparam int DW = 32;
  localparam int XFR_LSB = 0;
  localparam int XFR_W = 7;
  localparam int PKT_LSB = 19;
  localparam int PKT_W = 2;
  localparam int MPS_LSB = 0;
  localparam int MPS_W = 7;
  localparam int ENA_BIT = 31;
  localparam int QDEPTH = 256;
  localparam int QAW = 8;
  localparam int PKT_SLOTS = 8;
  localparam int PCW = 3;
  localparam logic [AW-1:0] CTRL0_OFF = 12'h900;
  localparam logic [AW-1:0] TSIZ0_OFF = 12'h910;
  localparam logic [AW-1:0] EP_STRIDE = 12'h020;
  localparam logic [DW-1:0] TSIZ_RST = 32'h0000_0000;
  localparam logic [DW-1:0] CTRL_RST = 32'h0000_0000;

  typedef logic [EPW-1:0] uie_ep_t;
  typedef logic [XFR_W-1:0] uie_size_t;
  typedef logic [PKT_W-1:0] uie_pcnt_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SEND = 2'b01,
    S_WAIT = 2'b10
  } uie_tx_st_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_CTRL = 2'b01,
    H_SIZE = 2'b10,
    H_DATA = 2'b11
  } uie_host_st_t;

  function automatic logic [AW-1:0] ctrl_addr(input uie_ep_t ep);
    ctrl_addr = CTRL0_OFF + AW'(ep) * EP_STRIDE;
  endfunction : ctrl_addr

  function automatic logic [AW-1:0] tsiz_addr(input uie_ep_t ep);
    tsiz_addr = TSIZ0_OFF + AW'(ep) * EP_STRIDE;
  endfunction : tsiz_addr
endpackage : uie_pkg

// file: design/uie_txq.sv
`timescale 1ns/1ns
module uie_txq (
  input logic clk,
  input logic rst_n,
  input logic wr_en,
  input logic [7:0] wr_data,
  input logic wr_last,
  input logic wr_zlp,
  input logic rd_next,
  input logic commit,
  input logic rewind,
  input logic drop_zlp,
  output logic [7:0] rd_byte,
  output uie_pkg::uie_size_t head_len,
  output logic has_data,
  output logic has_zlp,
  output logic push_done,
  output uie_pkg::uie_size_t push_len,
  output logic can_take
);
  import uie_pkg::*;

  logic [7:0] mem [QDEPTH];
  uie_size_t lens [PKT_SLOTS];
  logic [QAW:0] wp_r, wp_nxt, rp_r, rp_nxt, cp_r, cp_nxt;
  logic [PCW-1:0] lh_r, lh_nxt, lt_r, lt_nxt, cnt_r, cnt_nxt;
  logic full_r, full_nxt, zlp_r, zlp_nxt;
  uie_size_t acc_r, acc_nxt;
  logic [PCW:0] npk, npk_nxt;
  logic [QAW:0] used;
  logic pop;

  assign rd_byte = mem[rp_r[QAW-1:0]];
  assign head_len = lens[lh_r];
  assign has_data = full_r || (cnt_r != '0);
  assign has_zlp = zlp_r;
  assign push_done = wr_en && wr_last && !wr_zlp;
  assign push_len = acc_r + 7'h01;
  assign pop = commit && has_data;
  assign npk = {full_r, cnt_r};
  assign used = wp_r - cp_r;
  // Registered ready upstream: leave room for one write already in flight
  assign can_take = (used <= (QAW+1)'(QDEPTH - 2)) && (npk <= 4'h6);

  always_comb begin
    wp_nxt = wp_r;
    acc_nxt = acc_r;
    lt_nxt = lt_r;
    lh_nxt = lh_r;
    rp_nxt = rp_r;
    cp_nxt = cp_r;
    if (wr_en && !wr_zlp) begin
      wp_nxt = wp_r + 9'h001;
      acc_nxt = wr_last ? '0 : acc_r + 7'h01;
    end
    if (push_done) begin
      lt_nxt = lt_r + 3'h1;
    end
    if (rd_next) begin
      rp_nxt = rp_r + 9'h001;
    end
    if (rewind) begin
      rp_nxt = cp_r;
    end
    if (pop) begin
      cp_nxt = rp_r;
      lh_nxt = lh_r + 3'h1;
    end
    npk_nxt = npk + {3'h0, push_done} - {3'h0, pop};
    cnt_nxt = npk_nxt[PCW-1:0];
    full_nxt = npk_nxt[PCW];
    // New marker wins over the clear of the one just sent
    zlp_nxt = (zlp_r && !drop_zlp) || (wr_en && wr_zlp);
  end

  always_ff @(posedge clk) begin
    if (wr_en && !wr_zlp) begin
      mem[wp_r[QAW-1:0]] <= wr_data;
    end
    if (push_done) begin
      lens[lt_r] <= push_len;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cp_r <= '0;
      lh_r <= '0;
      lt_r <= '0;
      cnt_r <= '0;
      full_r <= 1'b0;
      zlp_r <= 1'b0;
      acc_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cp_r <= cp_nxt;
      lh_r <= lh_nxt;
      lt_r <= lt_nxt;
      cnt_r <= cnt_nxt;
      full_r <= full_nxt;
      zlp_r <= zlp_nxt;
      acc_r <= acc_nxt;
    end
  end
endmodule : uie_txq

// file: tb/uie_checker.sv
`timescale 1ns/1ns
module uie_checker (
  input logic CLK,
  input logic RST_N,
  input logic reg_rd,
  input logic reg_rvalid,
  input logic tok_valid,
  input logic tx_valid,
  input logic tx_last,
  input logic tx_zlp,
  input logic tx_nak,
  input logic hs_ack,
  input logic hs_miss
);
  import uie_pkg::*;
  // Tokens that land mid-packet are ignored, so only idle ones need an answer
  logic busy_r;
  logic busy_nxt;
  always_comb begin
    busy_nxt = busy_r;
    if (tok_valid && !busy_r) begin
      busy_nxt = 1'h1;
    end
    if (tx_nak || hs_ack || hs_miss) begin
      busy_nxt = 1'h0;
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_r <= 1'h0;
    end else begin
      busy_r <= busy_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_pkt_end;
    tx_valid && tx_last;
  endsequence
  sequence s_quiet;
    !tx_valid [*2];
  endsequence
  sequence s_first_byte;
    tx_valid && !$past(tx_valid);
  endsequence
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without read strobe");
  nak_timing_a: assert property (tx_nak |-> $past(tok_valid))
    else $error("nak not one cycle after token");
  zlp_timing_a: assert property (tx_zlp |-> $past(tok_valid))
    else $error("zero-length reply not one cycle after token");
  data_start_a: assert property (s_first_byte |-> $past(tok_valid, 2))
    else $error("first data byte not two cycles after token");
  bytes_back_a: assert property (tx_valid && !tx_last |=> tx_valid)
    else $error("gap inside a data packet");
  wait_quiet_a: assert property (s_pkt_end |=> s_quiet)
    else $error("data sent again before handshake");
  tx_onehot_a: assert property ($onehot0({tx_valid, tx_zlp, tx_nak}))
    else $error("more than one reply kind at once");
  token_answer_a: assert property (tok_valid && !busy_r |->
    ##[1:2] (tx_nak || tx_zlp || tx_valid))
    else $error("idle token got no reply");
endmodule : uie_checker

// file: tb/uie_tb_top.sv
`timescale 1ns/1ns
module uie_tb_top;
  import uie_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic xfer_start = 1'h0;
  uie_ep_t xfer_ep = '0;
  uie_size_t xfer_size = '0;
  uie_pcnt_t xfer_pkts = '0;
  uie_size_t xfer_mps = '0;
  logic xfer_busy;
  logic data_valid = 1'h0;
  logic [7:0] data_byte = 8'h00;
  logic data_taken;
  logic stat_req = 1'h0;
  logic [AW-1:0] stat_addr = '0;
  logic stat_valid;
  logic [DW-1:0] stat_data;
  logic token_req = 1'h0;
  uie_ep_t token_ep = '0;
  logic hs_drop = 1'h0;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic rx_last;
  logic rx_zlp;
  logic rx_nak;
  logic [NUM_EP-1:0] ep_active;
  int mismatches = 0;
  int check_count = 0;
  uie_if bus_if ();
  uie_dev u_uie_dev (.CLK(clk), .RST_N(rst_n), .BUS(bus_if), .EP_ACTIVE(ep_active));
  uie_host u_uie_host (.CLK(clk), .RST_N(rst_n), .BUS(bus_if), .XFER_START(xfer_start),
    .XFER_EP(xfer_ep), .XFER_SIZE(xfer_size), .XFER_PKTS(xfer_pkts), .XFER_MPS(xfer_mps),
    .XFER_BUSY(xfer_busy), .DATA_VALID(data_valid), .DATA_BYTE(data_byte),
    .DATA_TAKEN(data_taken), .STAT_REQ(stat_req), .STAT_ADDR(stat_addr),
    .STAT_VALID(stat_valid), .STAT_DATA(stat_data), .TOKEN_REQ(token_req),
    .TOKEN_EP(token_ep), .HS_DROP(hs_drop), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
    .RX_LAST(rx_last), .RX_ZLP(rx_zlp), .RX_NAK(rx_nak));
  uie_checker u_uie_checker (.CLK(clk), .RST_N(rst_n), .reg_rd(bus_if.reg_rd),
    .reg_rvalid(bus_if.reg_rvalid), .tok_valid(bus_if.tok_valid),
    .tx_valid(bus_if.tx_valid), .tx_last(bus_if.tx_last), .tx_zlp(bus_if.tx_zlp),
    .tx_nak(bus_if.tx_nak), .hs_ack(bus_if.hs_ack), .hs_miss(bus_if.hs_miss));
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected 0x%08h seen 0x%08h", what, exp, got);
    end
  endtask : check_val
  task automatic timed_out(input string what);
    mismatches++;
    $display("wrong value %s expected done seen timeout", what);
    stop_test();
  endtask : timed_out
  task automatic stat_read(input logic [AW-1:0] addr, input logic [31:0] exp, input string what);
    int k;
    @(posedge clk);
    stat_req <= 1'h1;
    stat_addr <= addr;
    @(posedge clk);
    stat_req <= 1'h0;
    k = 0;
    while (stat_valid !== 1'h1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20) timed_out(what);
    check_val(what, exp, stat_data);
  endtask : stat_read
  // Byte held until the taken pulse is seen, so none is skipped or doubled
  task automatic load(input uie_ep_t ep, input uie_size_t size, input uie_pcnt_t pkts,
                      input uie_size_t mps, input logic [7:0] base);
    int k;
    @(posedge clk);
    xfer_start <= 1'h1;
    xfer_ep <= ep;
    xfer_size <= size;
    xfer_pkts <= pkts;
    xfer_mps <= mps;
    @(posedge clk);
    xfer_start <= 1'h0;
    for (int i = 0; i < size; i++) begin
      data_valid <= 1'h1;
      data_byte <= base + 8'(i);
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (data_taken !== 1'h1 && k < 50);
      if (k >= 50) timed_out("data_taken");
    end
    data_valid <= 1'h0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (xfer_busy !== 1'h0 && k < 100);
    if (k >= 100) timed_out("xfer_busy");
    repeat (3) @(posedge clk);
  endtask : load
  task automatic token(input uie_ep_t ep, input logic drop, input int n_exp,
                       input logic [7:0] base, input logic [1:0] kind);
    int n;
    int k;
    logic zlp;
    logic nak;
    logic done;
    n = 0;
    k = 0;
    zlp = 1'h0;
    nak = 1'h0;
    done = 1'h0;
    @(posedge clk);
    token_req <= 1'h1;
    token_ep <= ep;
    hs_drop <= drop;
    @(posedge clk);
    token_req <= 1'h0;
    while (!done && k < 20) begin
      @(posedge clk);
      k++;
      if (rx_valid === 1'h1) begin
        check_val("rx_byte", 32'(base + 8'(n)), 32'(rx_byte));
        n++;
        done = (rx_last === 1'h1);
      end
      zlp = zlp | (rx_zlp === 1'h1);
      nak = nak | (rx_nak === 1'h1);
      done = done | zlp | nak;
    end
    check_val("rx_count", 32'(n_exp), 32'(n));
    check_val("rx_zlp", 32'(kind == 2'h1), 32'(zlp));
    check_val("rx_nak", 32'(kind == 2'h2), 32'(nak));
    repeat (4) @(posedge clk);
    hs_drop <= 1'h0;
  endtask : token
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    stat_read(TSIZ0_OFF, TSIZ_RST, "tsiz0_reset");
    check_val("ep_active", 32'h0, 32'(ep_active));
    $display("test reset done");
  endtask : t_reset
  // Five bytes, four per packet: one full packet then a short one
  task automatic t_multi;
    load(2'h0, 7'h05, 2'h2, 7'h04, 8'h10);
    check_val("ep_active", 32'h1, 32'(ep_active));
    stat_read(CTRL0_OFF, (32'h1 << ENA_BIT) | 32'h0000_0004, "ctrl0_loaded");
    stat_read(TSIZ0_OFF, 32'(2) << PKT_LSB, "tsiz0_loaded");
    token(2'h0, 1'h0, (2 - 1) * 4, 8'h10, 2'h0);
    stat_read(TSIZ0_OFF, 32'(1) << PKT_LSB, "tsiz0_one_sent");
    token(2'h0, 1'h0, 5 - 4, 8'h14, 2'h0);
    stat_read(TSIZ0_OFF, 32'h0, "tsiz0_done");
    check_val("ep_active", 32'h0, 32'(ep_active));
    token(2'h0, 1'h0, 0, 8'h00, 2'h2);
    $display("test multi done");
  endtask : t_multi
  task automatic t_zlp;
    load(2'h1, 7'h00, 2'h1, 7'h04, 8'h00);
    stat_read(12'h930, 32'(1) << PKT_LSB, "tsiz1_loaded");
    stat_read(TSIZ0_OFF, 32'h0, "tsiz0_untouched");
    token(2'h1, 1'h0, 0, 8'h00, 2'h1);
    check_val("ep_active", 32'h0, 32'(ep_active));
    $display("test zlp done");
  endtask : t_zlp
  // Lost handshake must leave the count alone and resend the same bytes
  task automatic t_retry;
    load(2'h2, 7'h03, 2'h1, 7'h08, 8'h40);
    token(2'h2, 1'h1, 3, 8'h40, 2'h0);
    stat_read(12'h950, 32'(1) << PKT_LSB, "tsiz2_missed");
    token(2'h2, 1'h0, 3, 8'h40, 2'h0);
    stat_read(12'h950, 32'h0, "tsiz2_done");
    check_val("ep_active", 32'h0, 32'(ep_active));
    $display("test retry done");
  endtask : t_retry
  task automatic t_split;
    token(2'h3, 1'h0, 0, 8'h00, 2'h2);
    load(2'h3, 7'h04, 2'h1, 7'h04, 8'h60);
    token(2'h3, 1'h0, 4, 8'h60, 2'h0);
    load(2'h3, 7'h00, 2'h1, 7'h04, 8'h00);
    token(2'h3, 1'h0, 0, 8'h00, 2'h1);
    stat_read(12'h970, 32'h0, "tsiz3_done");
    check_val("ep_active", 32'h0, 32'(ep_active));
    $display("test split done");
  endtask : t_split
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    t_reset();
    t_multi();
    t_zlp();
    t_retry();
    t_split();
    stop_test();
  end
  // Whole-run limit so a stuck handshake cannot hang the run
  initial begin
    repeat (20000) @(posedge clk);
    timed_out("run");
  end
endmodule : uie_tb_top
